// ### phy_link_pkg.sv
// Constants shared by the link control and status logic.
// Assumes a single 50 MHz clock; all times are converted to cycles here.
package phy_link_pkg;

  // Clock rate
  localparam int CLK_MHZ = 50;

  // Register indices on the management port
  localparam logic [4:0] BASIC_LINK_STATUS_ADDR = 5'h01;
  localparam logic [4:0] LIVE_PHY_STATUS_ADDR   = 5'h11;
  localparam logic [4:0] AUXILIARY_CONTROL_ADDR = 5'h12;

  // Field positions
  localparam int BLS_LINK_BIT      = 2;
  localparam int LPS_LINK_BIT      = 2;
  localparam int LPS_DUPLEX_BIT    = 1;
  localparam int LPS_SPEED_LO_BIT  = 3;
  localparam int AUX_AUTO_MDIX_BIT = 15;
  localparam int AUX_MDIX_SEL_BIT  = 14;
  localparam int AUX_LEGACY_BIT    = 9;

  // Values after reset
  localparam logic AUX_AUTO_MDIX_RST = 1'b1;
  localparam logic AUX_MDIX_SEL_RST  = 1'b0;
  localparam logic AUX_LEGACY_RST    = 1'b0;
  localparam logic BLS_LINK_RST      = 1'b0;
  localparam logic [15:0] RDATA_RST  = 16'h0000;

  // Resolved speed encoding
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  // Pulse timing in microseconds, with derived cycle counts
  localparam int SEARCH_INTERVAL_US  = 150;
  localparam int FLP_INTERVAL_US     = 125;
  localparam int FLP_TOLERANCE_US    = 14;
  localparam int SEARCH_INTERVAL_CYC = SEARCH_INTERVAL_US * CLK_MHZ;
  localparam int FLP_INTERVAL_CYC    = FLP_INTERVAL_US * CLK_MHZ;
  localparam int FLP_TOLERANCE_CYC   = FLP_TOLERANCE_US * CLK_MHZ;

  // Activity LED hold time
  localparam int ACT_HOLD_MS  = 50;
  localparam int ACT_HOLD_CYC = ACT_HOLD_MS * 1000 * CLK_MHZ;

  // Width of interval counters
  localparam int CNT_W = 24;

endpackage

// ### pulse_interval.sv
// Periodic one-cycle pulse generator.
// Counts only while enabled; restarts from zero when disabled.
`timescale 1ns/1ps
module pulse_interval #(
  parameter int PERIOD_CYC = 7500
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic enable_i,
  output logic      pulse_o
);
  import phy_link_pkg::*;

  logic [CNT_W-1:0] count_r;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD_CYC - 1);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !enable_i)
    begin
      count_r <= '0;
      pulse_o <= 1'b0;
    end
    else if (count_r == LAST)
    begin
      count_r <= '0;
      pulse_o <= 1'b1;
    end
    else
    begin
      count_r <= count_r + 1'b1;
      pulse_o <= 1'b0;
    end
  end

endmodule

// ### activity_stretch.sv
// Stretches short activity events into a visible LED level.
// A new event restarts the hold so bursts keep the LED lit.
`timescale 1ns/1ps
module activity_stretch #(
  parameter int HOLD_CYC = 2500000
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic event_i,
  output logic      led_o
);
  import phy_link_pkg::*;

  logic [CNT_W-1:0] hold_r;
  localparam logic [CNT_W-1:0] LOAD = CNT_W'(HOLD_CYC);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      hold_r <= '0;
      led_o  <= 1'b0;
    end
    else if (event_i)
    begin
      hold_r <= LOAD;
      led_o  <= 1'b1;
    end
    else if (hold_r != '0)
    begin
      hold_r <= hold_r - 1'b1;
      led_o  <= (hold_r != CNT_W'(1));
    end
    else
    begin
      led_o <= 1'b0;
    end
  end

endmodule

// ### phy_link_control_status.sv
// Link control and status logic of a 10/100/1000 twisted-pair transceiver.
// Assumes line-side status inputs are synchronous to clk_i and that strap
// pins arrive already resolved by their pad pull resistors.
//
// Summary of operation
// - With gigabit negotiation off, the role is fixed by the captured role strap.
// - With automatic crossover on and no link up, a search pulse goes out every 150 us.
// - Fast link pulses are spaced 125 us apart, within 14 us, apart from search pulses.
// - Clearing bit 15 of auxiliary_control stops the crossover search.
// - With search off, bit 14 of auxiliary_control picks crossover (1) or straight (0).
// - A speed LED lights only with good link at that LED's speed.
// - Bit 2 of basic_link_status latches low on link loss until it is read.
// - live_phy_status shows live link, speed and duplex with no latching.
// - Legacy gigabit mode is on when its strap is high or bit 9 is written one.
// - The activity LED lights on idle errors or packet transfers.
// - Straps are sampled on the first edge after reset release and a floating strap takes its pull default.
`timescale 1ns/1ps
module phy_link_control_status #(
  parameter int SEARCH_CYC = phy_link_pkg::SEARCH_INTERVAL_CYC,
  parameter int FLP_CYC    = phy_link_pkg::FLP_INTERVAL_CYC,
  parameter int ACT_CYC    = phy_link_pkg::ACT_HOLD_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Management register port
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_wr_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic [15:0]      reg_rdata_o,
  output logic             reg_rvalid_o,
  // Straps
  input  wire logic        role_strap_i,
  input  wire logic        legacy_strap_i,
  // Configuration level
  input  wire logic        autoneg_enable_setting_i,
  // Line-side status from the negotiation and receive logic
  input  wire logic        negotiated_master_i,
  input  wire logic        negotiating_i,
  input  wire logic        link_up_i,
  input  wire logic [1:0]  speed_i,
  input  wire logic        full_duplex_i,
  input  wire logic        idle_error_i,
  input  wire logic        packet_i,
  // Control outputs
  output logic             master_o,
  output logic             crossover_o,
  output logic             search_pulse_o,
  output logic             flp_pulse_o,
  output logic             legacy_mode_o,
  // LEDs
  output logic             led_1000_o,
  output logic             led_100_o,
  output logic             led_10_o,
  output logic             led_activity_o
);
  import phy_link_pkg::*;

  function automatic logic speed_led(input logic       link,
                                     input logic [1:0] speed,
                                     input logic [1:0] match);
    speed_led = link && (speed == match);
  endfunction

  // Strap capture
  logic role_strap_r;
  logic legacy_strap_r;
  logic strap_done_r;

  // auxiliary_control fields
  logic aux_auto_mdix_r;
  logic aux_mdix_sel_r;
  logic aux_legacy_r;

  // Latched-low link bit
  logic bls_link_r;
  logic bls_link_nxt;

  // Crossover search, FLP and activity state
  logic search_orient_r;
  logic search_tick;
  logic flp_tick;
  logic act_level;

  logic rd_bls;
  logic wr_aux;
  logic [15:0] rdata_nxt;

  assign rd_bls = reg_rd_i && (reg_addr_i == BASIC_LINK_STATUS_ADDR);
  assign wr_aux = reg_wr_i && (reg_addr_i == AUXILIARY_CONTROL_ADDR);

  // Captured once on the first edge after reset release; a level held
  // only during reset is not trusted, so capture happens out of reset.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      strap_done_r   <= 1'b0;
      role_strap_r   <= 1'b0;
      legacy_strap_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_done_r   <= 1'b1;
      role_strap_r   <= role_strap_i;
      legacy_strap_r <= legacy_strap_i;
    end
  end

  // auxiliary_control register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      aux_auto_mdix_r <= AUX_AUTO_MDIX_RST;
      aux_mdix_sel_r  <= AUX_MDIX_SEL_RST;
      aux_legacy_r    <= AUX_LEGACY_RST;
    end
    else if (wr_aux)
    begin
      aux_auto_mdix_r <= reg_wdata_i[AUX_AUTO_MDIX_BIT];
      aux_mdix_sel_r  <= reg_wdata_i[AUX_MDIX_SEL_BIT];
      aux_legacy_r    <= reg_wdata_i[AUX_LEGACY_BIT];
    end
  end

  // A read reloads the live link; a loss in that same cycle still wins.
  always_comb
  begin
    if (rd_bls)
    begin
      bls_link_nxt = link_up_i;
    end
    else
    begin
      bls_link_nxt = bls_link_r && link_up_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      bls_link_r <= BLS_LINK_RST;
    end
    else
    begin
      bls_link_r <= bls_link_nxt;
    end
  end

  // Read data mux; unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = 16'h0000;
    case (reg_addr_i)
      BASIC_LINK_STATUS_ADDR:
      begin
        rdata_nxt[BLS_LINK_BIT] = bls_link_r;
      end
      LIVE_PHY_STATUS_ADDR:
      begin
        rdata_nxt[LPS_LINK_BIT]   = link_up_i;
        rdata_nxt[LPS_DUPLEX_BIT] = full_duplex_i;
        rdata_nxt[LPS_SPEED_LO_BIT +: 2] = speed_i;
      end
      AUXILIARY_CONTROL_ADDR:
      begin
        rdata_nxt[AUX_AUTO_MDIX_BIT] = aux_auto_mdix_r;
        rdata_nxt[AUX_MDIX_SEL_BIT]  = aux_mdix_sel_r;
        rdata_nxt[AUX_LEGACY_BIT]    = aux_legacy_r;
      end
      default:
      begin
        rdata_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o  <= RDATA_RST;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        reg_rdata_o <= rdata_nxt;
      end
    end
  end

  // Role selection; forcing the role can clash with a forced partner
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      master_o <= 1'b0;
    end
    else if (!autoneg_enable_setting_i)
    begin
      master_o <= role_strap_r;
    end
    else
    begin
      master_o <= negotiated_master_i;
    end
  end

  // Crossover search runs only while enabled and no link is held
  pulse_interval #(
    .PERIOD_CYC (SEARCH_CYC)
  ) u_search (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .enable_i (aux_auto_mdix_r && !link_up_i),
    .pulse_o  (search_tick)
  );

  // FLP timer runs at nominal spacing, well inside the tolerance band
  pulse_interval #(
    .PERIOD_CYC (FLP_CYC)
  ) u_flp (
    .clk_i    (clk_i),
    .rst_n_i  (rst_n_i),
    .enable_i (negotiating_i),
    .pulse_o  (flp_tick)
  );

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      search_orient_r <= 1'b0;
    end
    else if (search_tick)
    begin
      search_orient_r <= !search_orient_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      search_pulse_o <= 1'b0;
      flp_pulse_o    <= 1'b0;
    end
    else
    begin
      search_pulse_o <= search_tick;
      flp_pulse_o    <= flp_tick;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      crossover_o <= 1'b0;
    end
    else if (aux_auto_mdix_r)
    begin
      crossover_o <= search_orient_r;
    end
    else
    begin
      crossover_o <= aux_mdix_sel_r;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      legacy_mode_o <= 1'b0;
    end
    else
    begin
      legacy_mode_o <= legacy_strap_r || aux_legacy_r;
    end
  end

  // Speed LEDs
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      led_1000_o <= 1'b0;
      led_100_o  <= 1'b0;
      led_10_o   <= 1'b0;
    end
    else
    begin
      led_1000_o <= speed_led(link_up_i, speed_i, SPEED_1000);
      led_100_o  <= speed_led(link_up_i, speed_i, SPEED_100);
      led_10_o   <= speed_led(link_up_i, speed_i, SPEED_10);
    end
  end

  // Single-cycle events are too short to see, hence the stretch
  activity_stretch #(
    .HOLD_CYC (ACT_CYC)
  ) u_act (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .event_i (idle_error_i || packet_i),
    .led_o   (act_level)
  );

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      led_activity_o <= 1'b0;
    end
    else
    begin
      led_activity_o <= act_level;
    end
  end

endmodule

// ### phy_link_control_status_monitor.sv
// Concurrent checks on the link control and status block ports.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
module phy_link_control_status_monitor
  import phy_link_pkg::*;
#(
  parameter int SEARCH_CYC = 20,
  parameter int FLP_CYC    = 16,
  parameter int ACT_CYC    = 10
) (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [4:0]  reg_addr_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic        role_strap_i,
  input wire logic        autoneg_enable_setting_i,
  input wire logic        link_up_i,
  input wire logic [1:0]  speed_i,
  input wire logic        packet_i,
  input wire logic        master_o,
  input wire logic        crossover_o,
  input wire logic        search_pulse_o,
  input wire logic        legacy_mode_o,
  input wire logic        led_1000_o,
  input wire logic        led_activity_o
);
  logic        auto_r;
  logic        sel_r;
  logic [15:0] gap_r;
  logic        strap_seen_r;
  logic        strap_role_r;
  wire         aux_wr = reg_wr_i && reg_addr_i == AUXILIARY_CONTROL_ADDR;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // Shadow of the crossover fields, as written
  always_ff @(posedge clk_i)
    if (!rst_n_i)
    begin
      auto_r <= AUX_AUTO_MDIX_RST;
      sel_r  <= AUX_MDIX_SEL_RST;
    end
    else if (aux_wr)
    begin
      auto_r <= reg_wdata_i[AUX_AUTO_MDIX_BIT];
      sel_r  <= reg_wdata_i[AUX_MDIX_SEL_BIT];
    end

  // Role strap as captured on the first edge out of reset; later pin
  // changes must not move the forced role
  always_ff @(posedge clk_i)
    if (!rst_n_i)
      strap_seen_r <= 1'b0;
    else if (!strap_seen_r)
    begin
      strap_seen_r <= 1'b1;
      strap_role_r <= role_strap_i;
    end

  // Saturating distance since the last search pulse
  always_ff @(posedge clk_i)
    if (!rst_n_i)
      gap_r <= 16'hffff;
    else if (search_pulse_o)
      gap_r <= 16'h0001;
    else if (gap_r != 16'hffff)
      gap_r <= gap_r + 16'h0001;

  chk_read_answer: assert property (
    reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
  chk_live_fields: assert property (
    reg_rd_i && reg_addr_i == LIVE_PHY_STATUS_ADDR
    |=> reg_rdata_o[4:2] == {$past(speed_i), $past(link_up_i)})
    else $error("live status fields wrong");
  chk_latch_loss: assert property (
    !link_up_i ##1 (reg_rd_i && reg_addr_i == BASIC_LINK_STATUS_ADDR)
    |=> !reg_rdata_o[BLS_LINK_BIT]) else $error("link loss not latched");
  chk_gig_led: assert property (
    $past(rst_n_i) |-> led_1000_o == $past(link_up_i && speed_i == SPEED_1000))
    else $error("gigabit led wrong");
  chk_act_led: assert property (
    packet_i |-> ##2 led_activity_o) else $error("activity led dark");
  chk_auto_off: assert property (
    !auto_r [*4] |-> !search_pulse_o) else $error("search while off");
  chk_manual_pair: assert property (
    !auto_r [*3] |-> crossover_o == $past(sel_r))
    else $error("manual pairing wrong");
  chk_search_gap: assert property (
    search_pulse_o |-> gap_r >= SEARCH_CYC) else $error("search too soon");
  chk_legacy_write: assert property (
    aux_wr && reg_wdata_i[AUX_LEGACY_BIT] |-> ##2 legacy_mode_o)
    else $error("legacy mode not entered");
  chk_forced_role: assert property (
    strap_seen_r && $past(strap_seen_r) && !$past(autoneg_enable_setting_i)
    |-> master_o == strap_role_r) else $error("forced role wrong");

  cov_read: cover property (reg_rvalid_o);
  cov_search: cover property (search_pulse_o);
  cov_act: cover property (led_activity_o && led_1000_o);
  cov_manual: cover property (!auto_r && crossover_o);
endmodule

bind phy_link_control_status phy_link_control_status_monitor #(
  .SEARCH_CYC (SEARCH_CYC),
  .FLP_CYC    (FLP_CYC),
  .ACT_CYC    (ACT_CYC)
) mon (.*);

// ### link_partner_model.sv
// Remote link partner model driving the link, speed, idle error and packet inputs.
// Link follows the bench request, promptly or a few cycles late.
`timescale 1ns/1ps
module link_partner_model (
  input  wire logic       clk_i,
  input  wire logic       want_up_i,
  input  wire logic [1:0] want_speed_i,
  input  wire logic       slow_i,
  output logic            link_up_o,
  output logic [1:0]      speed_o,
  output logic            idle_error_o,
  output logic            packet_o
);
  logic [3:0] dly_r = 4'h0;
  logic [3:0] pkt_r = 4'h0;

  always_ff @(posedge clk_i)
  begin
    dly_r        <= {dly_r[2:0], want_up_i};
    link_up_o    <= slow_i ? dly_r[3] : want_up_i;
    // No resolved speed without link, so keep it moving
    speed_o      <= want_up_i ? want_speed_i : ~speed_o;
    pkt_r        <= pkt_r + 4'h1;
    packet_o     <= link_up_o && pkt_r == 4'hf;
    idle_error_o <= link_up_o && !want_up_i;
  end
endmodule

// ### test_phy_link_control_status.sv
// Self-checking bench for the link control and status block.
// Bench drives register port, straps, negotiation and duplex; partner drives link, speed, errors and packets.
`timescale 1ns/1ps
module test_phy_link_control_status;
  import phy_link_pkg::*;
  localparam int SC = 20;
  localparam int FC = 16;
  localparam int AC = 10;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [4:0]  reg_addr_i = 5'h00;
  logic        reg_rd_i = 1'b0;
  logic        reg_wr_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        role_strap_i = 1'b1;
  logic        legacy_strap_i = 1'b0;
  logic        autoneg_enable_setting_i = 1'b0;
  logic        negotiated_master_i = 1'b0;
  logic        negotiating_i = 1'b0;
  logic        full_duplex_i = 1'b1;
  logic        p_up = 1'b1;
  logic [1:0]  p_spd = 2'h2;
  wire  [15:0] reg_rdata_o;
  wire  [1:0]  speed_i;
  wire         reg_rvalid_o, link_up_i, idle_error_i, packet_i, master_o;
  wire         crossover_o, search_pulse_o, flp_pulse_o, legacy_mode_o;
  wire         led_1000_o, led_100_o, led_10_o, led_activity_o;
  int          failures = 0;
  int          checks_done = 0;
  int          n;
  logic [15:0] v;
  logic        x;

  always #10 clk_i = ~clk_i;

  phy_link_control_status #(.SEARCH_CYC(SC), .FLP_CYC(FC), .ACT_CYC(AC))
    dut (.*);

  link_partner_model peer (
    .clk_i        (clk_i),
    .want_up_i    (p_up),
    .want_speed_i (p_spd),
    .slow_i       (1'b0),
    .link_up_o    (link_up_i),
    .speed_o      (speed_i),
    .idle_error_o (idle_error_i),
    .packet_o     (packet_i)
  );

  task automatic finish_test();
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("rvalid", reg_rvalid_o, 16'h0001);
    d = reg_rdata_o;
  endtask

  // Polls each cycle; a pulse lasts one cycle so none is missed
  task automatic wait_for(input int sel, input int lim, output int cnt);
    logic s;
    cnt = 0;
    do
    begin
      tick(1);
      cnt++;
      s = sel == 0 ? search_pulse_o : sel == 1 ? flp_pulse_o : led_activity_o;
      if (cnt > lim)
      begin
        failures++;
        finish_test();
      end
    end
    while (s !== 1'b1);
  endtask

  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    reg_read(AUXILIARY_CONTROL_ADDR, v);
    chk("aux reset", v, 16'h8000);
    chk("forced role", master_o, 16'h0001);
    chk("legacy strap low", legacy_mode_o, 16'h0000);
    reg_read(5'h05, v);
    chk("unmapped", v, 16'h0000);
    reg_write(LIVE_PHY_STATUS_ADDR, 16'hffff);
    reg_read(LIVE_PHY_STATUS_ADDR, v);
    chk("live status", v, 16'h0016);
    full_duplex_i <= 1'b0;
    reg_read(LIVE_PHY_STATUS_ADDR, v);
    chk("half duplex", v, 16'h0014);
    reg_read(BASIC_LINK_STATUS_ADDR, v);
    reg_read(BASIC_LINK_STATUS_ADDR, v);
    chk("link held", v & 16'h0004, 16'h0004);
    for (int s = 0; s < 3; s++)
    begin
      p_spd <= s[1:0];
      tick(3);
      chk("speed leds", {led_1000_o, led_100_o, led_10_o}, 16'h1 << s);
    end
    p_up <= 1'b0;
    tick(3);
    chk("leds no link", {led_1000_o, led_100_o, led_10_o}, 16'h0);
    reg_read(BASIC_LINK_STATUS_ADDR, v);
    chk("latched while down", v & 16'h0004, 16'h0000);
    wait_for(0, SC + 4, n);
    x = crossover_o;
    wait_for(0, SC + 4, n);
    chk("search gap", n >= SC && n <= SC + 1, 16'h0001);
    chk("search toggle", crossover_o, !x);
    p_up <= 1'b1;
    tick(3);
    reg_read(BASIC_LINK_STATUS_ADDR, v);
    chk("latched low", v & 16'h0004, 16'h0000);
    reg_read(BASIC_LINK_STATUS_ADDR, v);
    chk("second read", v & 16'h0004, 16'h0004);
    wait_for(2, 40, n);
    p_up <= 1'b0;
    tick(AC + 20);
    chk("activity idle", led_activity_o, 16'h0000);
    negotiating_i <= 1'b1;
    wait_for(1, FC + 4, n);
    wait_for(1, FC + 4, n);
    chk("flp gap", n >= FC - 1 && n <= FC + 1, 16'h0001);
    negotiating_i <= 1'b0;
    reg_write(AUXILIARY_CONTROL_ADDR, 16'h4200);
    tick(1);
    chk("manual cross", crossover_o, 16'h0001);
    chk("legacy by write", legacy_mode_o, 16'h0001);
    reg_read(AUXILIARY_CONTROL_ADDR, v);
    chk("aux readback", v, 16'h4200);
    reg_write(AUXILIARY_CONTROL_ADDR, 16'h0000);
    tick(1);
    chk("manual straight", crossover_o, 16'h0000);
    chk("legacy off", legacy_mode_o, 16'h0000);
    autoneg_enable_setting_i <= 1'b1;
    tick(2);
    chk("negotiated role", master_o, 16'h0000);
    autoneg_enable_setting_i <= 1'b0;
    tick(2);
    chk("forced again", master_o, 16'h0001);
    rst_n_i        <= 1'b0;
    role_strap_i   <= 1'b0;
    legacy_strap_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    tick(3);
    chk("new role strap", master_o, 16'h0000);
    chk("legacy strap", legacy_mode_o, 16'h0001);
    role_strap_i <= 1'b1;
    tick(2);
    chk("strap held", master_o, 16'h0000);
    negotiated_master_i      <= 1'b1;
    autoneg_enable_setting_i <= 1'b1;
    tick(2);
    chk("negotiated master", master_o, 16'h0001);
    finish_test();
  end
endmodule
